// *** rtl/ssf_pkg.sv ***
// shared constants of the serial sample chain framer
package ssf_pkg;
  // ==========================================================
  // timing
  localparam int unsigned CLK_HZ       = 40_000_000;
  localparam int unsigned BAUD_DEF     = 9600;
  localparam int unsigned CYCLE_HZ_DEF = 10;
  localparam int unsigned BAUD_CLKS    = (CLK_HZ + BAUD_DEF / 2) / BAUD_DEF;
  localparam int unsigned CYCLE_CLKS   = CLK_HZ / CYCLE_HZ_DEF;
  localparam int unsigned BAUD_FAST    = 115_200;
  localparam int unsigned FAST_CLKS    = CLK_HZ / BAUD_FAST;
  localparam int unsigned FAST_HZ      = 250;
  // ==========================================================
  // register word offsets (byte address)
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_BAUD     = 8'h04;
  localparam logic [7:0] REG_CYCLE    = 8'h08;
  localparam logic [7:0] REG_PREAMBLE = 8'h0C;
  localparam logic [7:0] REG_INT      = 8'h10;
  localparam logic [7:0] REG_FRAC     = 8'h14;
  localparam logic [7:0] REG_STATUS   = 8'h18;
  // ==========================================================
  // fields and reset values
  localparam int unsigned CTRL_EN_BIT   = 0;
  localparam int unsigned CTRL_PPS_BIT  = 1;
  localparam logic [1:0]  CTRL_RST      = 2'h1;
  localparam int unsigned PRE_HEAD_LSB  = 0;
  localparam int unsigned PRE_FOLL_LSB  = 8;
  localparam int unsigned INT_OVER_BIT  = 20;
  localparam int unsigned ST_FOLL_BIT   = 0;
  localparam int unsigned ST_BUSY_BIT   = 1;
  localparam int unsigned ST_SYNC_BIT   = 2;
  localparam int unsigned ST_SLOW_BIT   = 3;
  localparam int unsigned REC_LEN       = 14;
  localparam int unsigned BITS_PER_CHAR = 10;
  // ==========================================================
  // characters
  localparam logic [7:0] CH_DOLLAR = 8'h24;
  localparam logic [7:0] CH_COMMA  = 8'h2C;
  localparam logic [7:0] CH_ONE    = 8'h31;
  localparam logic [7:0] CH_SPACE  = 8'h20;
  localparam logic [7:0] CH_DOT    = 8'h2E;
  localparam logic [7:0] CH_ZERO   = 8'h30;
  localparam logic [7:0] CH_CR     = 8'h0D;
  localparam logic [7:0] CH_LF     = 8'h0A;
endpackage

// *** rtl/ssf_uart_tx.sv ***
// serial character transmitter, lsb first, one start and one stop bit
module ssf_uart_tx (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [15:0] div,
  input  wire logic        valid,
  input  wire logic [7:0]  data,
  output logic             ready,
  output logic             txd
);
  // ==========================================================
  // shifter
  logic [9:0]  sh_q;
  logic [3:0]  nb_q;
  logic [15:0] cnt_q;
  logic        busy_q;
  wire         bit_end = (cnt_q == div - 16'h0001);
  assign ready = ~busy_q;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      sh_q   <= 10'h3FF;
      nb_q   <= 4'h0;
      cnt_q  <= 16'h0000;
      busy_q <= 1'b0;
      txd    <= 1'b1;
    end else if (!busy_q) begin
      txd <= 1'b1;
      if (valid) begin
        sh_q   <= {1'b1, data, 1'b0};
        busy_q <= 1'b1;
        nb_q   <= 4'h0;
        cnt_q  <= 16'h0000;
        txd    <= 1'b0;
      end
    end else if (bit_end) begin
      cnt_q <= 16'h0000;
      if (nb_q == 4'(ssf_pkg::BITS_PER_CHAR - 1)) begin
        busy_q <= 1'b0;
        txd    <= 1'b1;
      end else begin
        nb_q <= nb_q + 4'h1;
        sh_q <= {1'b1, sh_q[9:1]};
        txd  <= sh_q[1];
      end
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end
endmodule

// *** rtl/ssf_uart_rx.sv ***
// serial character receiver with input synchroniser
module ssf_uart_rx (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [15:0] div,
  input  wire logic        rxd,
  output logic             valid,
  output logic [7:0]       data
);
  // ==========================================================
  // synchroniser and sampler
  logic        s1_q;
  logic        s2_q;
  logic        busy_q;
  logic [3:0]  nb_q;
  logic [15:0] cnt_q;
  logic [7:0]  sh_q;
  wire  [15:0] half = {1'b0, div[15:1]};
  wire         smp  = busy_q & (cnt_q == ((nb_q == 4'h0) ? half : div) - 16'h0001);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s1_q   <= 1'b1;
      s2_q   <= 1'b1;
      busy_q <= 1'b0;
      nb_q   <= 4'h0;
      cnt_q  <= 16'h0000;
      sh_q   <= 8'h00;
      valid  <= 1'b0;
      data   <= 8'h00;
    end else begin
      s1_q  <= rxd;
      s2_q  <= s1_q;
      valid <= 1'b0;
      if (!busy_q) begin
        cnt_q <= 16'h0000;
        nb_q  <= 4'h0;
        if (!s2_q) begin
          busy_q <= 1'b1;
        end
      end else if (smp) begin
        cnt_q <= 16'h0000;
        nb_q  <= nb_q + 4'h1;
        if (nb_q == 4'h0 && s2_q) begin
          busy_q <= 1'b0;
        end else if (nb_q == 4'(ssf_pkg::BITS_PER_CHAR - 1)) begin
          busy_q <= 1'b0;
          valid  <= s2_q;
          data   <= sh_q;
        end else if (nb_q != 4'h0) begin
          sh_q <= {s2_q, sh_q[7:1]};
        end
      end else begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end
endmodule

// *** rtl/ssf_framer.sv ***
// sample record framer and chain forwarder with wishbone registers
// Notes on behaviour
// - reset gives 9600 baud 8N1, 10 Hz cycle, ascii records
// - head module starts each record with a dollar preamble
// - record ends with carriage return then line feed
// - second character is '1' when reading is over threshold, else space
// - positions 3-7 five digits, 8 a point, 9-12 four digits
// - records are printable ascii, cr at 13, lf at 14
// - after the first upstream lf, upstream characters are forwarded to the data output
// - forwarded cr becomes a comma, forwarded lf is dropped
// - own record follows the forwarded upstream data
// - only the last module's cr lf pair ends the joined line
// - head uses dollar preamble, followers use comma preamble
// - every module powers up as head of chain
// - upstream data at the input switches the module to follower
// - follower mode holds until the next reset
// - follower sends nothing until the first upstream lf has arrived
// - follower aligns its sample timing to upstream arrival
// - link must run 115200 baud or more at 250 Hz or faster
// - pulse per second input realigns head sampling at any rate
module ssf_framer #(
  parameter int unsigned BAUD_CLKS  = ssf_pkg::BAUD_CLKS,
  parameter int unsigned CYCLE_CLKS = ssf_pkg::CYCLE_CLKS
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        cmd_rxd,
  input  wire logic        pps_in,
  output logic             data_txd,
  output logic             follower_o
);
  // ==========================================================
  // elaboration checks
  if (BAUD_CLKS < 4 || BAUD_CLKS > 65535) begin : g_baud_chk
    $error("baud divisor out of range");
  end
  if (CYCLE_CLKS < ssf_pkg::REC_LEN * ssf_pkg::BITS_PER_CHAR * BAUD_CLKS) begin : g_cyc_chk
    $error("cycle too short for one record");
  end

  typedef enum logic [0:0] {ST_IDLE, ST_SEND} ssf_state_t;

  // ==========================================================
  // helpers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] digit(input logic [3:0] d);
    return ssf_pkg::CH_ZERO | {4'h0, d};
  endfunction

  function automatic logic [7:0] rec_char(input logic [3:0] idx, input logic [7:0] pre,
                                          input logic over, input logic [19:0] ip,
                                          input logic [15:0] fp);
    logic [7:0] c;
    c = ssf_pkg::CH_SPACE;
    case (idx)
      4'd0:    c = pre;
      4'd1:    c = over ? ssf_pkg::CH_ONE : ssf_pkg::CH_SPACE;
      4'd2:    c = digit(ip[19:16]);
      4'd3:    c = digit(ip[15:12]);
      4'd4:    c = digit(ip[11:8]);
      4'd5:    c = digit(ip[7:4]);
      4'd6:    c = digit(ip[3:0]);
      4'd7:    c = ssf_pkg::CH_DOT;
      4'd8:    c = digit(fp[15:12]);
      4'd9:    c = digit(fp[11:8]);
      4'd10:   c = digit(fp[7:4]);
      4'd11:   c = digit(fp[3:0]);
      4'd12:   c = ssf_pkg::CH_CR;
      4'd13:   c = ssf_pkg::CH_LF;
      default: c = ssf_pkg::CH_SPACE;
    endcase
    return c;
  endfunction

  // ==========================================================
  // registers
  logic [1:0]  ctrl_q;
  logic [15:0] baud_q;
  logic [31:0] cycle_q;
  logic [15:0] pre_q;
  logic [20:0] int_q;
  logic [15:0] frac_q;
  logic        follower_q;
  logic        synced_q;
  logic        rec_req_q;
  logic        fwd_pend_q;
  logic [7:0]  fwd_char_q;
  logic [31:0] cnt_q;
  logic        pps1_q;
  logic        pps2_q;
  logic        pps3_q;
  ssf_state_t  state_q;
  logic [3:0]  idx_q;
  logic [7:0]  snap_pre_q;
  logic [20:0] snap_int_q;
  logic [15:0] snap_frac_q;

  // ==========================================================
  // bus decode
  wire        req     = wb_cyc_i & wb_stb_i;
  wire        wr_now  = req & wb_we_i & wb_ack_o;
  wire [7:0]  adr     = {wb_adr_i[7:2], 2'b00};
  wire        tx_rdy;
  wire        slow    = cycle_q < 32'(ssf_pkg::REC_LEN * ssf_pkg::BITS_PER_CHAR) * {16'h0, baud_q};
  wire [31:0] status  = {28'h0, slow, synced_q, (state_q == ST_SEND) | ~tx_rdy, follower_q};
  wire [31:0] rd_mux  = (adr == ssf_pkg::REG_CTRL)     ? {30'h0, ctrl_q} :
                        (adr == ssf_pkg::REG_BAUD)     ? {16'h0, baud_q} :
                        (adr == ssf_pkg::REG_CYCLE)    ? cycle_q :
                        (adr == ssf_pkg::REG_PREAMBLE) ? {16'h0, pre_q} :
                        (adr == ssf_pkg::REG_INT)      ? {11'h0, int_q} :
                        (adr == ssf_pkg::REG_FRAC)     ? {16'h0, frac_q} :
                        (adr == ssf_pkg::REG_STATUS)   ? status : 32'h0000_0000;
  wire [31:0] wr_val  = merge(rd_mux, wb_dat_i, wb_sel_i);
  wire        wr_ctrl = wr_now & (adr == ssf_pkg::REG_CTRL);
  wire        wr_baud = wr_now & (adr == ssf_pkg::REG_BAUD);
  wire        wr_cyc  = wr_now & (adr == ssf_pkg::REG_CYCLE);
  wire        wr_pre  = wr_now & (adr == ssf_pkg::REG_PREAMBLE);
  wire        wr_int  = wr_now & (adr == ssf_pkg::REG_INT);
  wire        wr_frac = wr_now & (adr == ssf_pkg::REG_FRAC);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_dat_o <= rd_mux;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      ctrl_q <= ssf_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= wr_val[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      baud_q <= 16'(BAUD_CLKS);
    end else if (wr_baud) begin
      baud_q <= wr_val[15:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cycle_q <= CYCLE_CLKS;
    end else if (wr_cyc) begin
      cycle_q <= wr_val;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pre_q <= {ssf_pkg::CH_COMMA, ssf_pkg::CH_DOLLAR};
    end else if (wr_pre) begin
      pre_q <= wr_val[15:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      int_q <= 21'h00_0000;
    end else if (wr_int) begin
      int_q <= wr_val[20:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      frac_q <= 16'h0000;
    end else if (wr_frac) begin
      frac_q <= wr_val[15:0];
    end
  end

  // ==========================================================
  // serial ends
  wire       rx_valid;
  wire [7:0] rx_data;
  logic      tx_valid;
  logic [7:0] tx_data;

  ssf_uart_rx u_rx (
    .clk   (clk),
    .rstn  (rstn),
    .div   (baud_q),
    .rxd   (cmd_rxd),
    .valid (rx_valid),
    .data  (rx_data)
  );

  ssf_uart_tx u_tx (
    .clk   (clk),
    .rstn  (rstn),
    .div   (baud_q),
    .valid (tx_valid),
    .data  (tx_data),
    .ready (tx_rdy),
    .txd   (data_txd)
  );

  // ==========================================================
  // cycle timing and pps
  wire pps_rise  = pps2_q & ~pps3_q & ctrl_q[ssf_pkg::CTRL_PPS_BIT];
  wire cyc_end   = (cnt_q >= cycle_q - 32'h0000_0001);
  wire up_lf     = follower_q & synced_q & rx_valid & (rx_data == ssf_pkg::CH_LF);
  wire head_tick = ~follower_q & ctrl_q[ssf_pkg::CTRL_EN_BIT] & (cyc_end | pps_rise);

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pps1_q <= 1'b0;
      pps2_q <= 1'b0;
      pps3_q <= 1'b0;
    end else begin
      pps1_q <= pps_in;
      pps2_q <= pps1_q;
      pps3_q <= pps2_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      cnt_q <= 32'h0000_0000;
    end else if (cyc_end | pps_rise | up_lf) begin
      cnt_q <= 32'h0000_0000;
    end else begin
      cnt_q <= cnt_q + 32'h0000_0001;
    end
  end

  // ==========================================================
  // chain mode and forwarding
  wire start_rec = (state_q == ST_IDLE) & rec_req_q & ~fwd_pend_q;
  wire fwd_take  = (state_q == ST_IDLE) & fwd_pend_q & tx_rdy;
  wire fwd_set   = follower_q & synced_q & rx_valid & (rx_data != ssf_pkg::CH_LF);
  wire [7:0] fwd_val = (rx_data == ssf_pkg::CH_CR) ? ssf_pkg::CH_COMMA : rx_data;

  always_ff @(posedge clk) begin
    if (!rstn) begin
      follower_q <= 1'b0;
      follower_o <= 1'b0;
    end else begin
      follower_q <= follower_q | rx_valid;
      follower_o <= follower_q | rx_valid;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      synced_q <= 1'b0;
    end else if (follower_q & rx_valid & (rx_data == ssf_pkg::CH_LF)) begin
      synced_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      rec_req_q  <= 1'b0;
      fwd_pend_q <= 1'b0;
      fwd_char_q <= 8'h00;
    end else begin
      rec_req_q  <= head_tick | up_lf | (rec_req_q & ~start_rec);
      fwd_pend_q <= fwd_set | (fwd_pend_q & ~fwd_take);
      if (fwd_set) begin
        fwd_char_q <= fwd_val;
      end
    end
  end

  // ==========================================================
  // record sender
  always_comb begin
    tx_valid = 1'b0;
    tx_data  = fwd_char_q;
    if (state_q == ST_SEND) begin
      tx_valid = 1'b1;
      tx_data  = rec_char(idx_q, snap_pre_q, snap_int_q[ssf_pkg::INT_OVER_BIT],
                          snap_int_q[19:0], snap_frac_q);
    end else if (fwd_pend_q) begin
      tx_valid = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_q     <= ST_IDLE;
      idx_q       <= 4'h0;
      snap_pre_q  <= ssf_pkg::CH_DOLLAR;
      snap_int_q  <= 21'h00_0000;
      snap_frac_q <= 16'h0000;
    end else begin
      case (state_q)
        ST_IDLE: begin
          idx_q <= 4'h0;
          if (start_rec) begin
            state_q     <= ST_SEND;
            snap_pre_q  <= follower_q ? pre_q[ssf_pkg::PRE_FOLL_LSB +: 8]
                                      : pre_q[ssf_pkg::PRE_HEAD_LSB +: 8];
            snap_int_q  <= int_q;
            snap_frac_q <= frac_q;
          end
        end
        ST_SEND: begin
          if (tx_rdy) begin
            if (idx_q == 4'(ssf_pkg::REC_LEN - 1)) begin
              state_q <= ST_IDLE;
            end
            idx_q <= idx_q + 4'h1;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
endmodule

// *** bench/ssf_framer_asserts.sv ***
// port checker for the sample chain framer
module ssf_framer_asserts #(
  parameter int unsigned BAUD_CLKS = ssf_pkg::BAUD_CLKS
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic cmd_rxd,
  input wire logic data_txd,
  input wire logic follower_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ======
  // helper counters
  localparam int unsigned QUIET = 20 * ssf_pkg::BITS_PER_CHAR * BAUD_CLKS;
  logic [31:0] low_run_q;
  logic [31:0] low_run_d;
  logic [31:0] quiet_q;
  logic [31:0] quiet_d;
  logic        seen_low_q;
  assign low_run_d = data_txd ? 32'h0 : low_run_q + 32'h1;
  assign quiet_d   = !cmd_rxd ? 32'h0 : (quiet_q[31] ? quiet_q : quiet_q + 32'h1);
  always_ff @(posedge clk) begin
    low_run_q  <= rstn ? low_run_d : 32'h0;
    quiet_q    <= rstn ? quiet_d : 32'h0;
    seen_low_q <= rstn & (seen_low_q | !cmd_rxd);
  end
  // ======
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence wb_req_s;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence ack_pulse_s;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  ack_answer_a: assert property (wb_req_s |=> ack_pulse_s)
    else $error("ack not a single pulse after request");
  ack_quiet_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  reset_state_a: assert property ($rose(rstn) |-> data_txd && !follower_o)
    else $error("not head with idle line after reset");
  idle_level_a: assert property ($rose(rstn) |=> data_txd [*8])
    else $error("line not idle high after reset");
  follower_hold_a: assert property (follower_o |=> follower_o)
    else $error("follower mode left without reset");
  follower_cause_a: assert property ($rose(follower_o) |-> seen_low_q)
    else $error("follower without upstream data");
  start_bit_a: assert property ($rose(data_txd) |-> (low_run_q % BAUD_CLKS) == 0)
    else $error("low run not whole bit times");
  quiet_stop_a: assert property (follower_o && quiet_q > QUIET |-> data_txd)
    else $error("follower sends without upstream");
endmodule
bind ssf_framer ssf_framer_asserts #(.BAUD_CLKS(BAUD_CLKS)) ssf_framer_asserts_i (
  .clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .cmd_rxd(cmd_rxd), .data_txd(data_txd), .follower_o(follower_o));

// *** bench/ssf_link_model.sv ***
// upstream sender and downstream receiver model of the serial chain
module ssf_link_model #(
  parameter int unsigned BAUD_CLKS = 8
) (
  input  wire logic       clk,
  input  wire logic       txd_in,
  output logic            rxd_out,
  output logic            got_valid,
  output logic [7:0]      got_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] sh;
  initial begin
    rxd_out = 1'b1;
    got_valid = 1'b0;
    got_data = 8'h00;
  end
  // ======
  // sender: same bit time as the block, data only, no commands
  task automatic send_char(input logic [7:0] c);
    logic [9:0] f;
    f = {1'b1, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rxd_out <= f[i];
      repeat (BAUD_CLKS) @(posedge clk);
    end
  endtask
  // ======
  // receiver: mid bit sampling, stop bit checked
  always begin
    @(negedge txd_in);
    repeat (BAUD_CLKS / 2) @(negedge clk);
    for (int i = 0; i < 8; i++) begin
      repeat (BAUD_CLKS) @(negedge clk);
      sh[i] = txd_in;
    end
    repeat (BAUD_CLKS) @(negedge clk);
    if (txd_in === 1'b1) begin
      got_data <= sh;
      got_valid <= 1'b1;
      @(negedge clk);
      got_valid <= 1'b0;
    end
  end
endmodule

// *** bench/ssf_framer_tb.sv ***
// self-checking bench for the sample chain framer
module ssf_framer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // ======
  // signals
  localparam int unsigned BC = 8;
  localparam int unsigned CC = 2000;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        wb_cyc = 1'b0;
  logic        wb_stb = 1'b0;
  logic        wb_we = 1'b0;
  logic [7:0]  wb_adr = 8'h00;
  logic [31:0] wb_wdat = 32'h0;
  logic [31:0] wb_rdat;
  logic        wb_ack;
  logic        cmd_rxd;
  logic        pps_in = 1'b0;
  logic        data_txd;
  logic        follower;
  logic        got_valid;
  logic [7:0]  got_data;
  logic [7:0]  got_q[$];
  int          errors = 0;
  int          comparisons = 0;
  ssf_framer #(.BAUD_CLKS(BC), .CYCLE_CLKS(CC)) ssf_framer_i (
    .clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack), .cmd_rxd(cmd_rxd), .pps_in(pps_in), .data_txd(data_txd),
    .follower_o(follower));
  ssf_link_model #(.BAUD_CLKS(BC)) ssf_link_model_i (.clk(clk), .txd_in(data_txd),
    .rxd_out(cmd_rxd), .got_valid(got_valid), .got_data(got_data));
  always #12.5 clk = ~clk;
  always @(posedge clk) if (got_valid === 1'b1) got_q.push_back(got_data);
  // ======
  // tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons=%0d errors=%0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                         output logic [31:0] rd);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_wdat <= wd;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    check({31'h0, wb_ack}, 32'h1);
    if (wb_ack !== 1'b1) end_of_test();
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] adr, input logic [31:0] d);
    logic [31:0] rd;
    wb_xfer(1'b1, adr, d, rd);
  endtask
  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] rd;
    wb_xfer(1'b0, adr, 32'h0, rd);
    check(rd, exp);
  endtask
  task automatic wait_chars(input int n);
    int k;
    k = 0;
    while (got_q.size() < n && k < 3 * CC) begin
      @(posedge clk);
      k++;
    end
    if (got_q.size() < n) begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got_q.size(), n);
      end_of_test();
    end
  endtask
  task automatic chk_rec(input int s, input logic [7:0] pre, input logic over,
                         input logic [19:0] ip, input logic [15:0] fp);
    logic [7:0] e[14];
    e[0] = pre;
    e[1] = over ? ssf_pkg::CH_ONE : ssf_pkg::CH_SPACE;
    for (int i = 0; i < 5; i++) e[2 + i] = ssf_pkg::CH_ZERO | {4'h0, ip[19 - 4 * i -: 4]};
    e[7] = ssf_pkg::CH_DOT;
    for (int i = 0; i < 4; i++) e[8 + i] = ssf_pkg::CH_ZERO | {4'h0, fp[15 - 4 * i -: 4]};
    e[12] = ssf_pkg::CH_CR;
    e[13] = ssf_pkg::CH_LF;
    for (int i = 0; i < 14; i++) check({24'h0, got_q[s + i]}, {24'h0, e[i]});
  endtask
  task automatic send4(input logic [31:0] w);
    for (int i = 3; i >= 0; i--) ssf_link_model_i.send_char(w[8 * i +: 8]);
  endtask
  // ======
  // sequence
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd_chk(ssf_pkg::REG_CTRL, {30'h0, ssf_pkg::CTRL_RST});
    rd_chk(ssf_pkg::REG_BAUD, BC);
    rd_chk(ssf_pkg::REG_CYCLE, CC);
    rd_chk(ssf_pkg::REG_PREAMBLE, 32'h0000_2C24);
    rd_chk(8'h1C, 32'h0);
    check({31'h0, follower}, 32'h0);
    $display("test reset values done");
    wr(ssf_pkg::REG_INT, 32'h0011_2345);
    wr(ssf_pkg::REG_FRAC, 32'h0000_6789);
    wait_chars(14);
    chk_rec(0, ssf_pkg::CH_DOLLAR, 1'b1, 20'h12345, 16'h6789);
    wr(ssf_pkg::REG_INT, 32'h0000_9876);
    wr(ssf_pkg::REG_FRAC, 32'h0000_0001);
    wait_chars(28);
    chk_rec(14, ssf_pkg::CH_DOLLAR, 1'b0, 20'h09876, 16'h0001);
    $display("test head records done");
    got_q.delete();
    send4({8'h7A, 8'h61, 8'h62, ssf_pkg::CH_LF});
    check({31'h0, follower}, 32'h1);
    got_q.delete();
    send4({8'h58, 8'h59, ssf_pkg::CH_CR, ssf_pkg::CH_LF});
    wait_chars(17);
    check({16'h0, got_q[0], got_q[1]}, 32'h0000_5859);
    check({24'h0, got_q[2]}, {24'h0, ssf_pkg::CH_COMMA});
    chk_rec(3, ssf_pkg::CH_COMMA, 1'b0, 20'h09876, 16'h0001);
    $display("test chain forwarding done");
    got_q.delete();
    repeat (3 * CC) @(posedge clk);
    check(got_q.size(), 32'h0);
    check({31'h0, follower}, 32'h1);
    $display("test upstream loss done");
    rstn <= 1'b0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    check({31'h0, follower}, 32'h0);
    got_q.delete();
    wait_chars(14);
    check({24'h0, got_q[0]}, {24'h0, ssf_pkg::CH_DOLLAR});
    $display("test second reset done");
    repeat (20) @(posedge clk);
    rd_chk(ssf_pkg::REG_STATUS, 32'h0);
    wr(ssf_pkg::REG_CTRL, 32'h3);
    pps_in <= 1'b1;
    repeat (4) @(posedge clk);
    pps_in <= 1'b0;
    rd_chk(ssf_pkg::REG_STATUS, 32'h2);
    wr(ssf_pkg::REG_CYCLE, 32'h0000_03E8);
    rd_chk(ssf_pkg::REG_STATUS, 32'hA);
    wait_chars(28);
    check({24'h0, got_q[14]}, {24'h0, ssf_pkg::CH_DOLLAR});
    $display("test pps and status done");
    end_of_test();
  end
endmodule
